// File: rtl/fcl_pkg.sv
// Constants, field layouts and carrier types for the fuse configuration loader
package fcl_pkg;
	localparam logic [3:0] FUSE_WDT      = 4'h0;
	localparam logic [3:0] FUSE_BOD      = 4'h1;
	localparam logic [3:0] FUSE_OSC      = 4'h2;
	localparam logic [3:0] FUSE_TIMER    = 4'h4;
	localparam logic [3:0] FUSE_SYS0     = 4'h5;
	localparam logic [3:0] FUSE_SYS1     = 4'h6;
	localparam logic [3:0] FUSE_APP_END  = 4'h7;
	localparam logic [3:0] FUSE_BOOT_END = 4'h8;
	localparam logic [3:0] FUSE_LOCK     = 4'hA;
	localparam logic [3:0] FUSE_LAST     = 4'hA;
	localparam logic [3:0] REG_STATUS    = 4'hC;
	localparam int         FUSE_COUNT    = 11;

	localparam logic [7:0] SYS0_RESET = 8'hC4;
	localparam logic [7:0] OSC_RESET  = 8'h02;
	localparam logic [7:0] SYS1_RESET = 8'h07;
	localparam logic [7:0] LOCK_KEY   = 8'hC5;

	localparam logic [1:0] FREQ_16MHZ = 2'h1;
	localparam logic [1:0] FREQ_20MHZ = 2'h2;
	localparam logic [1:0] PIN_GPIO   = 2'h0;
	localparam logic [1:0] PIN_DEBUG  = 2'h1;
	localparam logic [1:0] PIN_RESET  = 2'h2;
	localparam logic [1:0] SCAN_NONE  = 2'h3;

	localparam int OSC_LOCK_BIT = 7;
	localparam int KEEP_EE_BIT  = 0;
	localparam int STS_LOADED   = 0;
	localparam int STS_RELEASED = 1;
	localparam int STS_PIN_HOLD = 2;
	localparam int STS_LOCKED   = 3;

	localparam int CLK_HZ             = 20_000_000;
	localparam int STARTUP_UNIT_MS    = 1;
	localparam int MS_CYCLES          = CLK_HZ / 1000 * STARTUP_UNIT_MS;
	localparam int PIN_HOLD_SLOW      = 768;
	localparam int PIN_HOLD_W         = 10;
	localparam int STARTUP_W          = 7;

	typedef struct packed {
		logic [3:0] window;
		logic [3:0] period;
	} fcl_wdt_t;

	typedef struct packed {
		logic [2:0] threshold;
		logic       sample_rate;
		logic [1:0] active_mode;
		logic [1:0] sleep_mode;
	} fcl_bod_t;

	function automatic logic [7:0] fcl_fuse_default(input int idx);
		case (idx)
			FUSE_OSC:  return OSC_RESET;
			FUSE_SYS0: return SYS0_RESET;
			FUSE_SYS1: return SYS1_RESET;
			default:   return 8'h00;
		endcase
	endfunction : fcl_fuse_default
endpackage : fcl_pkg

// File: rtl/fcl_tick_divider.sv
// Enable pulse generator: one pulse every DIV cycles while running
`timescale 1ns/100ps
`default_nettype none
module fcl_tick_divider #(
	parameter int DIV = 20000
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Control
	input  wire logic run,
	output logic      tick
);
	localparam int W = $clog2(DIV + 1);
	logic [W-1:0] count;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (!run) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (count == W'(DIV - 1)) begin
			count <= '0;
			tick  <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule : fcl_tick_divider
`default_nettype wire

// File: rtl/fcl_down_counter.sv
// Loadable down counter stepped by an enable pulse
`timescale 1ns/100ps
`default_nettype none
module fcl_down_counter #(
	parameter int W = 10
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] load_value,
	input  wire logic         step,
	output logic              busy
);
	logic [W-1:0] count;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			count <= '0;
		else if (load)
			count <= load_value;
		else if (step && count != '0)
			count <= count - 1'b1;
	end

	assign busy = (count != '0);
endmodule : fcl_down_counter
`default_nettype wire

// File: rtl/fcl_loader.sv
// Fuse configuration loader: fetches fuses after reset and drives unit settings
`timescale 1ns/100ps
`default_nettype none
module fcl_loader
	import fcl_pkg::*;
#(
	parameter int         MS_DIV       = fcl_pkg::MS_CYCLES,
	parameter int         CAL_W        = 8,
	parameter logic [8:0] FLASH_BLOCKS = 9'h040
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Avalon-MM slave, word addressed
	input  wire logic [3:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	input  wire logic [3:0]         avs_byteenable,
	output logic [31:0]             avs_readdata,
	output logic                    avs_waitrequest,
	// Fuse storage read port, data one cycle after the strobe
	output logic                    fuse_rd,
	output logic [3:0]              fuse_addr,
	input  wire logic [7:0]         fuse_rdata,
	// Factory calibration values
	input  wire logic [CAL_W-1:0]   cal16_main,
	input  wire logic [CAL_W-1:0]   cal16_temp,
	input  wire logic [CAL_W-1:0]   cal20_main,
	input  wire logic [CAL_W-1:0]   cal20_temp,
	// Watchdog and brown-out settings
	output fcl_pkg::fcl_wdt_t       wdt_cfg,
	output fcl_pkg::fcl_bod_t       bod_cfg,
	// Main oscillator settings
	output logic                    osc_calib_lock,
	output logic [1:0]              osc_frequency_select,
	output logic [CAL_W-1:0]        osc_main_calibration,
	output logic [CAL_W-1:0]        osc_temp_calibration,
	// Control timer
	input  wire logic               debug_entry,
	input  wire logic               fault_on_debug,
	output logic [7:0]              timer_fault_control,
	output logic [3:0]              compare_pin_enable,
	output logic [3:0]              compare_default_level,
	output logic                    compare_level_load,
	// Memory scan and partitioning
	output logic [1:0]              scan_region_select,
	output logic                    scan_enable,
	output logic [8:0]              boot_section_end,
	output logic [8:0]              app_code_end,
	// Shared pin
	input  wire logic               slow_osc_tick,
	output logic [1:0]              shared_pin_function,
	output logic                    pin_out_disable,
	// Erase, lock and debug port
	input  wire logic               chip_erase_req,
	output logic                    eeprom_erase,
	output logic                    eeprom_keep_on_erase,
	output logic                    locked,
	input  wire logic               dbg_bus_req,
	input  wire logic               dbg_sib_req,
	output logic                    dbg_bus_grant,
	output logic                    dbg_sib_grant,
	// Processor start
	output logic                    cpu_release
);
	typedef enum logic [2:0] {LD_ISSUE, LD_CAPTURE, LD_APPLY, LD_DELAY, LD_RUN} fcl_state_t;

	fcl_state_t           state;
	logic [7:0]           shadow [FUSE_COUNT];
	logic [3:0]           idx;
	logic                 loaded;
	logic                 ms_tick;
	logic                 delay_busy;
	logic                 delay_load;
	logic [STARTUP_W-1:0] delay_ms;
	logic                 hold_load;
	logic                 hold_started;
	logic                 hold_busy;
	logic                 req;
	logic [7:0]           fuse_wdt;
	logic [7:0]           fuse_bod;
	logic [7:0]           fuse_osc;
	logic [7:0]           fuse_sys0;
	logic [2:0]           startup_delay_select;

	assign fuse_wdt  = shadow[FUSE_WDT];
	assign fuse_bod  = shadow[FUSE_BOD];
	assign fuse_osc  = shadow[FUSE_OSC];
	assign fuse_sys0 = shadow[FUSE_SYS0];
	assign startup_delay_select       = shadow[FUSE_SYS1][2:0];
	assign req       = avs_read || avs_write;

	// Fetch sequence, then apply, then start-up delay
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= LD_ISSUE;
			idx       <= 4'h0;
			fuse_rd   <= 1'b0;
			fuse_addr <= 4'h0;
			loaded    <= 1'b0;
		end else begin
			case (state)
				LD_ISSUE: begin
					fuse_rd   <= 1'b1;
					fuse_addr <= idx;
					state     <= LD_CAPTURE;
				end
				LD_CAPTURE: begin
					fuse_rd <= 1'b0;
					if (!fuse_rd) begin
						if (idx == FUSE_LAST) begin
							state <= LD_APPLY;
						end else begin
							idx   <= idx + 4'h1;
							state <= LD_ISSUE;
						end
					end
				end
				LD_APPLY: begin
					loaded <= 1'b1;
					state  <= LD_DELAY;
				end
				LD_DELAY: begin
					if (!delay_load && !delay_busy)
						state <= LD_RUN;
				end
				LD_RUN:  state <= LD_RUN;
				default: state <= LD_ISSUE;
			endcase
		end
	end

	// Fuse shadows; only the lock byte is writable from the bus
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < FUSE_COUNT; i++)
				shadow[i] <= fcl_fuse_default(i);
		end else if (state == LD_CAPTURE && !fuse_rd) begin
			shadow[idx] <= fuse_rdata;
		end else if (avs_write && !avs_waitrequest && avs_address == FUSE_LOCK
				&& avs_byteenable[0]) begin
			shadow[FUSE_LOCK] <= avs_writedata[7:0];
		end
	end

	// Watchdog, brown-out and oscillator settings
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_cfg              <= '0;
			bod_cfg              <= '0;
			osc_calib_lock       <= 1'b0;
			osc_frequency_select <= FREQ_20MHZ;
			osc_main_calibration <= '0;
			osc_temp_calibration <= '0;
		end else if (state == LD_APPLY) begin
			wdt_cfg.window       <= fuse_wdt[7:4];
			wdt_cfg.period       <= fuse_wdt[3:0];
			bod_cfg.threshold    <= fuse_bod[7:5];
			bod_cfg.sample_rate  <= fuse_bod[4];
			bod_cfg.active_mode  <= fuse_bod[3:2];
			bod_cfg.sleep_mode   <= fuse_bod[1:0];
			osc_calib_lock       <= fuse_osc[OSC_LOCK_BIT];
			osc_frequency_select <= fuse_osc[1:0];
			// Reserved codes leave the calibration untouched
			if (fuse_osc[1:0] == FREQ_16MHZ) begin
				osc_main_calibration <= cal16_main;
				osc_temp_calibration <= cal16_temp;
			end else if (fuse_osc[1:0] == FREQ_20MHZ) begin
				osc_main_calibration <= cal20_main;
				osc_temp_calibration <= cal20_temp;
			end
		end
	end

	// Control timer fault defaults
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_fault_control   <= 8'h00;
			compare_pin_enable    <= 4'h0;
			compare_default_level <= 4'h0;
			compare_level_load    <= 1'b0;
		end else begin
			compare_level_load <= (state == LD_APPLY)
				|| (loaded && debug_entry && fault_on_debug);
			if (state == LD_APPLY) begin
				timer_fault_control   <= shadow[FUSE_TIMER];
				compare_pin_enable    <= shadow[FUSE_TIMER][7:4];
				compare_default_level <= shadow[FUSE_TIMER][3:0];
			end
		end
	end

	// Scan region, flash partition and shared pin function
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_region_select   <= SCAN_NONE;
			scan_enable          <= 1'b0;
			boot_section_end     <= FLASH_BLOCKS;
			app_code_end         <= FLASH_BLOCKS;
			shared_pin_function  <= PIN_DEBUG;
			eeprom_keep_on_erase <= 1'b0;
		end else if (state == LD_APPLY) begin
			scan_region_select   <= fuse_sys0[7:6];
			scan_enable          <= (fuse_sys0[7:6] != SCAN_NONE);
			eeprom_keep_on_erase <= fuse_sys0[KEEP_EE_BIT];
			// Reserved pin code falls back to the debug port to keep access
			if (fuse_sys0[3:2] == PIN_GPIO || fuse_sys0[3:2] == PIN_RESET)
				shared_pin_function <= fuse_sys0[3:2];
			else
				shared_pin_function <= PIN_DEBUG;
			if (shadow[FUSE_BOOT_END] == 8'h00) begin
				boot_section_end <= FLASH_BLOCKS;
				app_code_end     <= FLASH_BLOCKS;
			end else begin
				boot_section_end <= {1'b0, shadow[FUSE_BOOT_END]};
				if (shadow[FUSE_APP_END] == 8'h00)
					app_code_end <= FLASH_BLOCKS;
				else
					app_code_end <= {1'b0, shadow[FUSE_APP_END]};
			end
		end
	end

	// Shared pin output hold after every reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hold_started <= 1'b0;
		else
			hold_started <= 1'b1;
	end

	assign hold_load = !hold_started;

	fcl_down_counter #(.W(PIN_HOLD_W)) u_pin_hold (
		.clk        (clk),
		.rst_n      (rst_n),
		.load       (hold_load),
		.load_value (PIN_HOLD_W'(PIN_HOLD_SLOW)),
		.step       (slow_osc_tick),
		.busy       (hold_busy)
	);

	// Driver stays off until the function is known, then through the hold when the function is GPIO
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pin_out_disable <= 1'b1;
		else
			pin_out_disable <= !loaded || hold_load
				|| (hold_busy && shared_pin_function == PIN_GPIO);
	end

	// Start-up delay in milliseconds
	always_comb begin
		delay_ms = '0;
		if (startup_delay_select != 3'h0)
			delay_ms = STARTUP_W'(1) << (startup_delay_select - 3'h1);
	end

	assign delay_load = (state == LD_APPLY);

	fcl_tick_divider #(.DIV(MS_DIV)) u_ms_div (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (state == LD_DELAY),
		.tick  (ms_tick)
	);

	fcl_down_counter #(.W(STARTUP_W)) u_startup (
		.clk        (clk),
		.rst_n      (rst_n),
		.load       (delay_load),
		.load_value (delay_ms),
		.step       (ms_tick),
		.busy       (delay_busy)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cpu_release <= 1'b0;
		else
			cpu_release <= (state == LD_RUN);
	end

	// Lock state, erase and debug gating
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			locked        <= 1'b1;
			eeprom_erase  <= 1'b0;
			dbg_bus_grant <= 1'b0;
			dbg_sib_grant <= 1'b0;
		end else begin
			locked        <= !loaded || (shadow[FUSE_LOCK] != LOCK_KEY);
			eeprom_erase  <= chip_erase_req
				&& (!eeprom_keep_on_erase || locked);
			dbg_bus_grant <= dbg_bus_req && !locked;
			dbg_sib_grant <= dbg_sib_req;
		end
	end

	// Avalon slave: every access answers on the second edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !(req && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				if (avs_address <= FUSE_LAST)
					avs_readdata <= {24'h00_0000, shadow[avs_address]};
				else if (avs_address == REG_STATUS)
					avs_readdata <= {28'h000_0000, locked, pin_out_disable,
						cpu_release, loaded};
				else
					avs_readdata <= 32'h0000_0000;
			end
		end
	end

	property p_wdt_window;
		@(posedge clk) disable iff (!rst_n)
		(state == LD_APPLY) |=> (wdt_cfg.window == $past(fuse_wdt[7:4]));
	endproperty
	a_wdt_window: assert property (p_wdt_window) else $error("window not loaded");

	property p_wdt_period;
		@(posedge clk) disable iff (!rst_n)
		(state == LD_APPLY) |=> (wdt_cfg.period == $past(fuse_wdt[3:0]));
	endproperty
	a_wdt_period: assert property (p_wdt_period) else $error("period not loaded");

	property p_bod;
		@(posedge clk) disable iff (!rst_n)
		(state == LD_APPLY) |=> (bod_cfg == $past(fuse_bod));
	endproperty
	a_bod: assert property (p_bod) else $error("brown-out fields wrong");

	property p_cal20;
		@(posedge clk) disable iff (!rst_n)
		(state == LD_APPLY && fuse_osc[1:0] == FREQ_20MHZ)
			|=> (osc_main_calibration == $past(cal20_main));
	endproperty
	a_cal20: assert property (p_cal20) else $error("20 MHz calibration wrong");

	property p_timer;
		@(posedge clk) disable iff (!rst_n)
		(state == LD_APPLY) |=> (timer_fault_control == $past(shadow[FUSE_TIMER]))
			&& compare_level_load;
	endproperty
	a_timer: assert property (p_timer) else $error("timer fault defaults wrong");

	property p_pin_hold;
		@(posedge clk) disable iff (!rst_n)
		(hold_busy && shared_pin_function == PIN_GPIO) |=> pin_out_disable;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin driven during hold");

	property p_erase_locked;
		@(posedge clk) disable iff (!rst_n)
		(chip_erase_req && locked) |=> eeprom_erase;
	endproperty
	a_erase_locked: assert property (p_erase_locked) else $error("locked erase kept EEPROM");

	property p_lock_key;
		@(posedge clk) disable iff (!rst_n)
		(loaded && shadow[FUSE_LOCK] != LOCK_KEY) |=> locked;
	endproperty
	a_lock_key: assert property (p_lock_key) else $error("invalid key left unlocked");

	property p_dbg_gate;
		@(posedge clk) disable iff (!rst_n)
		dbg_bus_grant |-> !$past(locked);
	endproperty
	a_dbg_gate: assert property (p_dbg_gate) else $error("bus granted while locked");

	property p_release;
		@(posedge clk) disable iff (!rst_n)
		$rose(cpu_release) |-> loaded && !delay_busy;
	endproperty
	a_release: assert property (p_release) else $error("released before load");
endmodule : fcl_loader
`default_nettype wire

// File: verif/fcl_fuse_store_model.sv
// Fuse storage model answering the loader's read strobe
`timescale 1ns/100ps
`default_nettype none
module fcl_fuse_store_model (
	// Clock
	input  wire logic             clk,
	// Read port
	input  wire logic             fuse_rd,
	input  wire logic [3:0]       fuse_addr,
	input  wire logic [15:0][7:0] image,
	output var  logic [7:0]       fuse_rdata = 8'hA5
);
	// Data valid only the cycle after a strobe; scrambled otherwise
	always @(posedge clk) begin
		if (fuse_rd) begin
			fuse_rdata <= image[fuse_addr];
		end else begin
			fuse_rdata <= ~fuse_rdata;
		end
	end
endmodule : fcl_fuse_store_model
`default_nettype wire

// File: verif/tb_fuse_config_loader.sv
// Self-checking bench for the fuse configuration loader
`timescale 1ns/100ps
`default_nettype none
module tb_fuse_config_loader;
	import fcl_pkg::*;
	localparam int MSD = 4;
	localparam int FB  = 64;
	logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, fuse_rd;
	logic [3:0]  avs_address, avs_byteenable, fuse_addr, compare_pin_enable, compare_default_level;
	logic [31:0] avs_writedata, avs_readdata;
	logic [7:0]  fuse_rdata, c16m, c16t, c20m, c20t, osc_main_calibration, osc_temp_calibration;
	logic [7:0]  timer_fault_control;
	fcl_wdt_t    wdt_cfg, wdt_at_rel;
	fcl_bod_t    bod_cfg;
	logic [1:0]  osc_frequency_select, scan_region_select, shared_pin_function;
	logic        osc_calib_lock, debug_entry, fault_on_debug, compare_level_load, scan_enable;
	logic [8:0]  boot_section_end, app_code_end;
	logic        slow_osc_tick, pin_out_disable, chip_erase_req, eeprom_erase, eeprom_keep_on_erase;
	logic        locked, dbg_bus_req, dbg_sib_req, dbg_bus_grant, dbg_sib_grant, cpu_release;
	logic [15:0][7:0] img;
	int fail_count, checks, seed, cyc, ticks, apply_cyc, rel_cyc, pin_ticks, timer;

	fcl_loader #(.MS_DIV(MSD)) u_dut (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fuse_rd(fuse_rd),
		.fuse_addr(fuse_addr), .fuse_rdata(fuse_rdata), .cal16_main(c16m), .cal16_temp(c16t),
		.cal20_main(c20m), .cal20_temp(c20t), .wdt_cfg(wdt_cfg), .bod_cfg(bod_cfg),
		.osc_calib_lock(osc_calib_lock), .osc_frequency_select(osc_frequency_select),
		.osc_main_calibration(osc_main_calibration), .osc_temp_calibration(osc_temp_calibration),
		.debug_entry(debug_entry), .fault_on_debug(fault_on_debug),
		.timer_fault_control(timer_fault_control), .compare_pin_enable(compare_pin_enable),
		.compare_default_level(compare_default_level), .compare_level_load(compare_level_load),
		.scan_region_select(scan_region_select), .scan_enable(scan_enable),
		.boot_section_end(boot_section_end), .app_code_end(app_code_end),
		.slow_osc_tick(slow_osc_tick), .shared_pin_function(shared_pin_function),
		.pin_out_disable(pin_out_disable), .chip_erase_req(chip_erase_req),
		.eeprom_erase(eeprom_erase), .eeprom_keep_on_erase(eeprom_keep_on_erase),
		.locked(locked), .dbg_bus_req(dbg_bus_req), .dbg_sib_req(dbg_sib_req),
		.dbg_bus_grant(dbg_bus_grant), .dbg_sib_grant(dbg_sib_grant), .cpu_release(cpu_release));

	fcl_fuse_store_model u_fuse (.clk(clk), .fuse_rd(fuse_rd), .fuse_addr(fuse_addr),
		.image(img), .fuse_rdata(fuse_rdata));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Slow oscillator runs at half the system rate to keep the hold short
	always @(posedge clk) slow_osc_tick <= ~slow_osc_tick;

	// Event times relative to reset release
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc = 0;
			ticks = 0;
			apply_cyc = -1;
			rel_cyc = -1;
			pin_ticks = -1;
		end else begin
			cyc = cyc + 1;
			if (slow_osc_tick) ticks = ticks + 1;
			if (compare_level_load && apply_cyc < 0) apply_cyc = cyc;
			if (cpu_release && rel_cyc < 0) begin
				rel_cyc = cyc;
				wdt_at_rel = wdt_cfg;
			end
			if (!pin_out_disable && pin_ticks < 0) pin_ticks = ticks;
		end
	end

	always @(posedge clk) begin
		timer = timer + 1;
		if (timer == 40000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	// Erase decision and debug port grants for a given lock state
	task automatic side_checks(input logic lk, input logic keep);
		@(posedge clk);
		chip_erase_req <= 1'b1;
		dbg_bus_req <= 1'b1;
		dbg_sib_req <= 1'b1;
		@(posedge clk);
		chip_erase_req <= 1'b0;
		@(negedge clk);
		check("eeprom erase", eeprom_erase, !keep || lk);
		check("bus grant", dbg_bus_grant, !lk);
		check("info grant", dbg_sib_grant, 1'b1);
		@(posedge clk);
		dbg_bus_req <= 1'b0;
		dbg_sib_req <= 1'b0;
	endtask : side_checks

	task automatic run_image(input int k);
		logic [15:0][7:0] im;
		logic [2:0]  kk;
		logic [31:0] q;
		logic [7:0]  cm, ct;
		logic        lk;
		int          startup_delay_select, n, seen;
		kk = 3'(k);
		im = {$random(seed), $random(seed), $random(seed), $random(seed)};
		im[1][7:5] = kk;
		im[1][3:2] = kk[1:0];
		im[1][1:0] = ~kk[1:0];
		im[2][1:0] = kk[1:0];
		im[5][7:6] = kk[1:0];
		im[5][3:2] = ~kk[1:0];
		im[6][2:0] = kk;
		if (!kk[0]) im[10] = LOCK_KEY;
		if (k == 2) im[8:7] = 16'h0000;
		@(posedge clk);
		rst_n <= 1'b0;
		img <= im;
		c16m <= 8'($random(seed));
		c16t <= 8'($random(seed));
		c20m <= 8'($random(seed));
		c20t <= 8'($random(seed));
		@(negedge clk);
		check("reset pin function", shared_pin_function, PIN_DEBUG);
		check("reset scan", scan_region_select, SCAN_NONE);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		n = 0;
		// CPU release and pin driver enable must both be seen before the bench touches anything else
		while ((rel_cyc < 0 || pin_ticks < 0) && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check("start-up wait", n < 3000, 1'b1);
		@(negedge clk);
		lk = (im[10] != LOCK_KEY);
		startup_delay_select = (im[6][2:0] == 3'h0) ? 0 : (1 << (im[6][2:0] - 1));
		cm = (im[2][1:0] == FREQ_16MHZ) ? c16m : (im[2][1:0] == FREQ_20MHZ) ? c20m : 8'h00;
		ct = (im[2][1:0] == FREQ_16MHZ) ? c16t : (im[2][1:0] == FREQ_20MHZ) ? c20t : 8'h00;
		check("window", wdt_cfg.window, im[0][7:4]);
		check("period", wdt_cfg.period, im[0][3:0]);
		check("watchdog at release", wdt_at_rel, im[0]);
		check("threshold", bod_cfg.threshold, im[1][7:5]);
		check("sample rate", bod_cfg.sample_rate, im[1][4]);
		check("active mode", bod_cfg.active_mode, im[1][3:2]);
		check("sleep mode", bod_cfg.sleep_mode, im[1][1:0]);
		check("osc lock", osc_calib_lock, im[2][7]);
		check("freq select", osc_frequency_select, im[2][1:0]);
		check("main cal", osc_main_calibration, cm);
		check("temp cal", osc_temp_calibration, ct);
		check("fault control", timer_fault_control, im[4]);
		check("cmp enable", compare_pin_enable, im[4][7:4]);
		check("cmp level", compare_default_level, im[4][3:0]);
		check("scan region", scan_region_select, im[5][7:6]);
		check("scan enable", scan_enable, im[5][7:6] != SCAN_NONE);
		check("pin function", shared_pin_function,
			(im[5][3:2] == 2'h3) ? PIN_DEBUG : im[5][3:2]);
		check("keep bit", eeprom_keep_on_erase, im[5][0]);
		check("boot end", boot_section_end, (im[8] == 8'h00) ? FB : im[8]);
		check("app end", app_code_end,
			(im[7] == 8'h00 || im[8] == 8'h00) ? FB : im[7]);
		check("locked", locked, lk);
		check("startup delay", (rel_cyc - apply_cyc >= startup_delay_select * MSD)
			&& (rel_cyc - apply_cyc <= startup_delay_select * MSD + 4), 1'b1);
		check("pin hold", (im[5][3:2] == PIN_GPIO) ? (pin_ticks >= 767 && pin_ticks <= 770)
			: (pin_ticks < 768), 1'b1);
		for (int i = 0; i <= 10; i++) begin
			bus(1'b0, 4'(i), 32'h0, q);
			check("fuse shadow", q, {24'h0, im[i]});
		end
		bus(1'b0, REG_STATUS, 32'h0, q);
		check("status", q, {28'h0, lk, 3'b011});
		bus(1'b0, 4'hD, 32'h0, q);
		check("unmapped", q, 32'h0);
		bus(1'b1, FUSE_WDT, {24'h0, ~im[0]}, q);
		bus(1'b0, FUSE_WDT, 32'h0, q);
		check("read-only fuse", q, {24'h0, im[0]});
		side_checks(lk, im[5][0]);
		@(posedge clk);
		fault_on_debug <= kk[0];
		debug_entry <= 1'b1;
		@(posedge clk);
		debug_entry <= 1'b0;
		seen = 0;
		repeat (5) begin
			@(negedge clk);
			if (compare_level_load === 1'b1) seen = 1;
		end
		check("debug level load", seen, kk[0]);
		bus(1'b1, FUSE_LOCK, lk ? {24'h0, LOCK_KEY} : 32'h3C, q);
		@(posedge clk);
		@(negedge clk);
		check("lock write", locked, !lk);
		side_checks(!lk, im[5][0]);
	endtask : run_image

	initial begin
		seed = 32'h1029e7d6;
		fail_count = 0;
		checks = 0;
		timer = 0;
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		img = '0;
		{c16m, c16t, c20m, c20t} = 32'h0;
		{debug_entry, fault_on_debug, slow_osc_tick, chip_erase_req} = 4'h0;
		{dbg_bus_req, dbg_sib_req} = 2'h0;
		for (int k = 0; k < 8; k++) run_image(k);
		finish_test();
	end
endmodule : tb_fuse_config_loader
`default_nettype wire
